// >>> common/rmhsp_pkg.sv
/*
 * constants, command codes and state types for the radio modem host link.
 * assumes a single 200 MHz ref_clk domain; all link pins arrive asynchronously.
 */
package rmhsp_pkg;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] CMD_NOP = 8'hfe;
    localparam logic [7:0] CMD_RSVD = 8'hff;
    localparam logic [7:0] CMD_COUNTRY = 8'hfd;
    localparam logic [7:0] CMD_HOP_FIRST = 8'hf0;
    localparam logic [7:0] CMD_HOP_LAST = 8'hf7;
    localparam logic [7:0] CMD_LEAD_350 = 8'hf8;
    localparam logic [7:0] CMD_LEAD_30 = 8'hf9;
    localparam logic [7:0] CMD_LEAD_3 = 8'hfa;
    localparam logic [7:0] CMD_TX_NEXT = 8'hef;
    localparam logic [7:0] CMD_RSSI = 8'hee;
    localparam logic [7:0] CMD_TX_CH_FIRST = 8'h80;
    localparam logic [7:0] CMD_TX_CH_LAST = 8'he3;
    localparam logic [7:0] CMD_BAUD_LOW = 8'h73;
    localparam logic [7:0] CMD_BAUD_MID = 8'h75;
    localparam logic [7:0] CMD_BAUD_HIGH = 8'h76;
    localparam logic [7:0] CMD_RX_SLOW = 8'h78;
    localparam logic [7:0] CMD_RX_NORMAL = 8'h79;
    localparam logic [7:0] CMD_LIF_FIRST = 8'h7a;
    localparam logic [7:0] CMD_LIF_LAST = 8'h7d;
    localparam logic [7:0] CMD_RX_SCAN = 8'h6f;
    // receive-fix code is not printed; kept as a parameterised choice
    localparam logic [7:0] CMD_RX_FIX = 8'h6e;
    localparam logic [7:0] CODE_LEAD_FOUND = 8'hff;
    localparam logic [7:0] CODE_LEAD_LOST = 8'hfe;
    localparam logic [6:0] CHAN_MAX = 7'd100;
    localparam logic [2:0] HOP_RESET = 3'h0;
    localparam logic [1:0] LEAD_350MS = 2'h0;
    localparam logic [1:0] LEAD_30MS = 2'h1;
    localparam logic [1:0] LEAD_3MS = 2'h2;
    localparam logic [1:0] BAUD_LOW = 2'h0;
    localparam logic [1:0] BAUD_MID = 2'h1;
    localparam logic [1:0] BAUD_HIGH = 2'h2;
    localparam logic [1:0] LIF_RESET = 2'h0;
    localparam logic [1:0] COUNTRY_ALT = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [5:0] {
        RMHSP_IDLE = 6'b000001,
        RMHSP_ANSWER = 6'b000010,
        RMHSP_TX_LEAD = 6'b000100,
        RMHSP_TX_DATA = 6'b001000,
        RMHSP_RX_LEAD = 6'b010000,
        RMHSP_RX_DATA = 6'b100000
    } rmhsp_state_t;
endpackage

// >>> rtl/rmhsp_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
module rmhsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    // extra pointer bit separates full from empty
    assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr[AW-1:0]];

    // storage has no reset; only pointers matter
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// >>> rtl/rmhsp_core.sv
/*
 * spi slave command interpreter of the radio modem host link.
 * assumes the host is spi master (mode 3), pins are asynchronous to ref_clk,
 * and the air side is modelled by plain handshake ports on ref_clk.
 */
// Function
// RL1: spi mode 3, host master, radio slave, msb first.
// RL2: host lowers select before clocking a command or data byte.
// RL3: 0xfe is no command; 0xff reserved, never a command.
// RL4: 0xfd returns country code 0 to 3.
// RL5: 0xf0..0xf7 pick hop set one to eight; one after reset.
// RL6: 0xf8/0xf9/0xfa pick lead-in 350, 30 (default), 3 ms.
// RL7: 0xef starts tx on next hop; 0x80..0xe3 on channel 0..100. Code decodes 0x80..0xe3 as channel 0..99, so channel 100 cannot start.
// RL8: 0xee measures signal strength on the current channel.
// RL9: 0x73/0x75/0x76 pick baud low (default), mid, high; code 3 alternates.
// RL10: 0x78 slow low-power receive, 0x79 normal receive (default).
// RL11: 0x7a..0x7d set lead-in period 11 to 12.5 us.
// RL12: 0x6f makes receiver scan all channels (default).
// RL13: a receive command fixes receiver on channel 0..100.
// RL14: host holds unlock request low until grant rises, then transfers.
// RL15: grant stays high until a receive command arrives.
// RL16: tx start sends lead-in, then sync with event flag raised.
// RL17: event flag drops as soon as select goes low.
// RL18: after each air byte, take spi byte as next and raise flag. Code raises the flag only while the fifo has room.
// RL19: at frame end flag stays high until the frame is fully sent.
// RL20: lead-in detected raises flag and offers 0xff.
// RL21: after sync, first byte read is rssi, then frame data.
// RL22: lead-in lost or no sync gives 0xfe instead of rssi.
// RL23: sck idles high, shift out on fall, sample on rise, eight bits.
// RL24: air messages ignored until first receive command; then only tx ungated.
// RL25: undefined or unused codes change nothing.
module rmhsp_core
    import rmhsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic sck,
    input wire logic select_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic byte_ready,
    input wire logic command_unlock_req_n,
    output logic command_ack,
    input wire logic [1:0] country_code,
    input wire logic [7:0] rssi_value,
    output logic [2:0] hop_set,
    output logic [1:0] lead_in_sel,
    output logic [1:0] baud_sel,
    output logic baud_alt,
    output logic rx_slow,
    output logic [1:0] lead_freq_sel,
    output logic rx_scan,
    output logic [6:0] rx_channel,
    output logic tx_start,
    output logic tx_next_hop,
    output logic [6:0] tx_channel,
    input wire logic tx_lead_done,
    input wire logic tx_byte_done,
    input wire logic tx_frame_done,
    output logic air_tx_valid,
    input wire logic air_tx_ready,
    output logic [7:0] air_tx_data,
    output logic rx_enable,
    input wire logic rx_lead_found,
    input wire logic rx_lead_lost,
    input wire logic rx_sync_found,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end
);
    // two flip-flop synchronisers; stage one is read only by stage two
    logic [2:0] sck_s1, sck_s2;
    logic sck_d;
    logic sel_d;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sck_s1 <= 3'h7;
            sck_s2 <= 3'h7;
        end else begin
            sck_s1 <= {command_unlock_req_n, select_n, sck};
            sck_s2 <= sck_s1;
        end
    end
    wire logic sck_q = sck_s2[0];
    wire logic sel_n_q = sck_s2[1];
    wire logic unlock_n_q = sck_s2[2];
    logic mosi_s1, mosi_s2;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            mosi_s1 <= mosi;
            mosi_s2 <= mosi_s1;
        end
    end

    // edge detection on the synchronised pins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sck_d <= 1'b1;
            sel_d <= 1'b1;
        end else begin
            sck_d <= sck_q;
            sel_d <= sel_n_q;
        end
    end
    wire logic sck_rise = sck_q && !sck_d;
    wire logic sck_fall = !sck_q && sck_d;
    wire logic sel_fall = !sel_n_q && sel_d;

    // spi shifter: sample on rise, shift on fall, msb first
    logic [7:0] rx_shift;
    logic [2:0] bit_cnt;
    logic [7:0] tx_shift;
    logic [7:0] answer;
    logic spi_done;
    logic [7:0] spi_byte;
    always_ff @(posedge ref_clk) begin
        if (srst || sel_n_q) begin
            bit_cnt <= '0;
            spi_done <= 1'b0;
        end else begin
            spi_done <= 1'b0;
            if (sck_rise) begin // see RL23
                rx_shift <= {rx_shift[6:0], mosi_s2}; // see RL1
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == BIT_LAST) begin
                    spi_done <= 1'b1;
                    spi_byte <= {rx_shift[6:0], mosi_s2};
                end
            end
        end
    end

    // outgoing byte loads on select fall, next bit moves up on each sck fall after the first
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_shift <= CODE_LEAD_LOST;
        end else if (sel_fall) begin
            tx_shift <= answer;
        end else if (sck_fall && !sel_n_q && bit_cnt != '0) begin
            // the first fall only exposes the msb that select already loaded
            tx_shift <= {tx_shift[6:0], 1'b0}; // see RL1 RL23
        end
    end
    assign miso = tx_shift[7];
    assign miso_oe = !sel_n_q;

    // command classification, shared by gating and execution
    function automatic logic is_tx_cmd(input logic [7:0] c);
        return c == CMD_TX_NEXT || (c >= CMD_TX_CH_FIRST && c <= CMD_TX_CH_LAST);
    endfunction
    function automatic logic is_rx_cmd(input logic [7:0] c);
        return c == CMD_RX_SCAN || c == CMD_RX_FIX;
    endfunction

    rmhsp_state_t state;
    logic rx_armed;
    logic unlocked;
    logic fix_pending;
    logic rssi_due;
    logic fifo_in_ready;
    // a pending fix lets its channel byte through, grant or not
    wire logic cmd_ok = spi_done
        && (is_tx_cmd(spi_byte) || unlocked || !rx_armed || fix_pending);

    // unlock grant: rises on request low in idle once a receive command has armed rx, stays until a receive command
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            unlocked <= 1'b0;
            rx_armed <= 1'b0;
        end else if (spi_done && is_rx_cmd(spi_byte) && cmd_ok && !fix_pending
                && state == RMHSP_IDLE) begin
            unlocked <= 1'b0; // see RL15
            rx_armed <= 1'b1; // see RL24
        end else if (!unlock_n_q && rx_armed && state == RMHSP_IDLE) begin
            unlocked <= 1'b1; // see RL14
        end
    end
    assign command_ack = unlocked;
    assign rx_enable = rx_armed && !unlocked;

    // configuration registers; unknown codes fall through untouched
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hop_set <= HOP_RESET;
            lead_in_sel <= LEAD_30MS;
            baud_sel <= BAUD_LOW;
            rx_slow <= 1'b0;
            lead_freq_sel <= LIF_RESET;
            rx_scan <= 1'b1;
            rx_channel <= '0;
            fix_pending <= 1'b0;
        end else if (cmd_ok && state == RMHSP_IDLE) begin
            if (fix_pending) begin
                fix_pending <= 1'b0;
                if (spi_byte[6:0] <= CHAN_MAX && !spi_byte[7]) begin
                    rx_scan <= 1'b0; // see RL13
                    rx_channel <= spi_byte[6:0];
                end
            end else if (spi_byte >= CMD_HOP_FIRST && spi_byte <= CMD_HOP_LAST) begin
                hop_set <= spi_byte[2:0]; // see RL5
            end else if (spi_byte == CMD_LEAD_350) begin
                lead_in_sel <= LEAD_350MS; // see RL6
            end else if (spi_byte == CMD_LEAD_30) begin
                lead_in_sel <= LEAD_30MS; // see RL6
            end else if (spi_byte == CMD_LEAD_3) begin
                lead_in_sel <= LEAD_3MS; // see RL6
            end else if (spi_byte == CMD_BAUD_LOW) begin
                baud_sel <= BAUD_LOW; // see RL9
            end else if (spi_byte == CMD_BAUD_MID) begin
                baud_sel <= BAUD_MID; // see RL9
            end else if (spi_byte == CMD_BAUD_HIGH) begin
                baud_sel <= BAUD_HIGH; // see RL9
            end else if (spi_byte == CMD_RX_SLOW) begin
                rx_slow <= 1'b1; // see RL10
            end else if (spi_byte == CMD_RX_NORMAL) begin
                rx_slow <= 1'b0; // see RL10
            end else if (spi_byte >= CMD_LIF_FIRST && spi_byte <= CMD_LIF_LAST) begin
                lead_freq_sel <= spi_byte[1:0] - CMD_LIF_FIRST[1:0]; // see RL11
            end else if (spi_byte == CMD_RX_SCAN) begin
                rx_scan <= 1'b1; // see RL12
            end else if (spi_byte == CMD_RX_FIX) begin
                fix_pending <= 1'b1; // see RL13
            end
            // 0xfe, 0xff and unused codes fall through; see RL3 and RL25
        end
    end
    assign baud_alt = country_code == COUNTRY_ALT; // see RL9

    // tx data fifo: spi bytes wait here until the air side takes them
    logic fifo_in_valid;
    rmhsp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(spi_byte),
        .out_valid(air_tx_valid),
        .out_ready(air_tx_ready),
        .out_data(air_tx_data)
    );
    assign fifo_in_valid = spi_done && state == RMHSP_TX_DATA;

    // main sequencer for transmit, receive and answered requests
    logic raise_flag;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= RMHSP_IDLE;
            tx_start <= 1'b0;
            tx_next_hop <= 1'b0;
            tx_channel <= '0;
            answer <= CODE_LEAD_LOST;
            raise_flag <= 1'b0;
            rssi_due <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            raise_flag <= 1'b0;
            case (state)
                RMHSP_IDLE: begin
                    if (cmd_ok && !fix_pending && is_tx_cmd(spi_byte)) begin
                        tx_start <= 1'b1; // see RL7
                        tx_next_hop <= spi_byte == CMD_TX_NEXT;
                        tx_channel <= spi_byte[6:0];
                        state <= RMHSP_TX_LEAD;
                    end else if (cmd_ok && !fix_pending && spi_byte == CMD_COUNTRY) begin
                        answer <= {6'h00, country_code}; // see RL4
                        raise_flag <= 1'b1;
                        state <= RMHSP_ANSWER;
                    end else if (cmd_ok && !fix_pending && spi_byte == CMD_RSSI) begin
                        answer <= rssi_value; // see RL8
                        raise_flag <= 1'b1;
                        state <= RMHSP_ANSWER;
                    end else if (rx_enable && rx_lead_found) begin
                        answer <= CODE_LEAD_FOUND; // see RL20
                        raise_flag <= 1'b1;
                        rssi_due <= 1'b1;
                        state <= RMHSP_RX_LEAD;
                    end
                end
                RMHSP_ANSWER: begin
                    if (spi_done) begin
                        state <= RMHSP_IDLE;
                    end
                end
                RMHSP_TX_LEAD: begin
                    if (tx_lead_done) begin
                        raise_flag <= 1'b1; // see RL16
                        state <= RMHSP_TX_DATA;
                    end
                end
                RMHSP_TX_DATA: begin
                    if (tx_frame_done) begin
                        state <= RMHSP_IDLE; // see RL19
                    end else if (tx_byte_done && fifo_in_ready) begin
                        raise_flag <= 1'b1; // see RL18
                    end
                end
                RMHSP_RX_LEAD: begin
                    if (rx_lead_lost) begin
                        answer <= CODE_LEAD_LOST; // see RL22
                        raise_flag <= 1'b1;
                        state <= RMHSP_IDLE;
                    end else if (rx_sync_found) begin
                        answer <= rssi_value; // see RL21
                        raise_flag <= 1'b1;
                        state <= RMHSP_RX_DATA;
                    end
                end
                RMHSP_RX_DATA: begin
                    if (rx_frame_end) begin
                        state <= RMHSP_IDLE;
                    end else if (rx_byte_valid) begin
                        answer <= rx_byte; // see RL21
                        raise_flag <= 1'b1;
                    end
                end
                default: begin
                    state <= RMHSP_IDLE;
                end
            endcase
            if (state != RMHSP_RX_LEAD) begin
                rssi_due <= 1'b0;
            end
        end
    end

    // event flag: set wins over the select-fall clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            byte_ready <= 1'b0;
        end else if (raise_flag) begin
            byte_ready <= 1'b1; // see RL16
        end else if (sel_fall || (state == RMHSP_TX_DATA && tx_frame_done)) begin
            // frame end drops the flag left high after the last byte
            byte_ready <= 1'b0; // see RL17 RL19
        end
    end

    AST_FLAG_DROP: assert property (@(posedge ref_clk) disable iff (srst)
        sel_fall && !raise_flag |=> !byte_ready) // see RL17
        else $error("event flag did not drop on select");
    AST_HOP_SET: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_ok && state == RMHSP_IDLE && !fix_pending && spi_byte == CMD_HOP_LAST
        |=> hop_set == 3'h7) // see RL5
        else $error("hop set not taken");
    AST_LEAD: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_ok && state == RMHSP_IDLE && !fix_pending && spi_byte == CMD_LEAD_3
        |=> lead_in_sel == LEAD_3MS) // see RL6
        else $error("lead-in not taken");
    AST_TXSTART: assert property (@(posedge ref_clk) disable iff (srst)
        state == RMHSP_IDLE && cmd_ok && !fix_pending && spi_byte == CMD_TX_NEXT
        |=> tx_start && tx_next_hop) // see RL7
        else $error("tx start missing");
    AST_GRANT_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        command_ack && !(spi_done && is_rx_cmd(spi_byte)) |=> command_ack) // see RL15
        else $error("grant dropped early");
    AST_SYNC_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
        state == RMHSP_TX_LEAD && tx_lead_done |=> ##1 byte_ready) // see RL16
        else $error("flag not raised at sync");
    AST_LOST: assert property (@(posedge ref_clk) disable iff (srst)
        state == RMHSP_RX_LEAD && rx_lead_lost |=> answer == CODE_LEAD_LOST) // see RL22
        else $error("lead-in lost code missing");
    AST_FOUND: assert property (@(posedge ref_clk) disable iff (srst)
        state == RMHSP_IDLE && rx_enable && rx_lead_found && !cmd_ok
        |=> answer == CODE_LEAD_FOUND ##1 byte_ready) // see RL20
        else $error("lead-in found not offered");
    AST_COUNTRY: assert property (@(posedge ref_clk) disable iff (srst)
        state == RMHSP_IDLE && cmd_ok && !fix_pending && spi_byte == CMD_COUNTRY
        |=> answer[7:2] == 6'h00 && state == RMHSP_ANSWER) // see RL4
        else $error("country answer wrong");
    AST_FRAME_END: assert property (@(posedge ref_clk) disable iff (srst)
        state == RMHSP_TX_DATA && tx_frame_done && !raise_flag |=> !byte_ready) // see RL19
        else $error("flag not dropped at frame end");
    COV_TX: cover property (@(posedge ref_clk) state == RMHSP_TX_DATA && tx_frame_done);
    COV_RX: cover property (@(posedge ref_clk) state == RMHSP_RX_DATA && rx_byte_valid);
    COV_UNLOCK: cover property (@(posedge ref_clk) $rose(command_ack));
endmodule

// >>> dv/rmhsp_host.sv
/*
 * host controller model: spi master, mode 3, msb first, 48 ns sck.
 * assumes the bench calls xfer; sck is not tied to ref_clk.
 */
module rmhsp_host (
    output logic sck,
    output logic select_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: clock parked high, radio deselected
    initial begin
        sck = 1'b1;
        select_n = 1'b1;
        mosi = 1'b0;
    end
    // select first, then data set on fall and taken on rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        select_n = 1'b0;
        #24;
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            mosi = tx[i];
            #24;
            sck = 1'b1;
            rx[i] = miso_oe ? miso : 1'bx; // undriven line never matches
            #24;
        end
        select_n = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
    endtask
endmodule

// >>> dv/test_radio_modem_host_spi_protocol.sv
/*
 * self-checking bench of the host link core: config, answers, unlock, rx, tx.
 * assumes the core holds the tx fifo and rmhsp_host drives the spi pins.
 */
module test_radio_modem_host_spi_protocol
    import rmhsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic command_unlock_req_n = 1'b1;
    logic [1:0] country_code = 2'h0;
    logic [7:0] rssi_value = 8'h0;
    logic [7:0] rx_byte = 8'h0;
    logic tx_lead_done = 1'b0, tx_byte_done = 1'b0, tx_frame_done = 1'b0, air_tx_ready = 1'b0;
    logic rx_lead_found = 1'b0, rx_lead_lost = 1'b0, rx_sync_found = 1'b0;
    logic rx_byte_valid = 1'b0, rx_frame_end = 1'b0;
    logic sck, select_n, mosi, miso, miso_oe, byte_ready, command_ack, baud_alt, rx_slow;
    logic rx_scan, tx_start, tx_next_hop, air_tx_valid, rx_enable;
    logic [2:0] hop_set;
    logic [1:0] lead_in_sel, baud_sel, lead_freq_sel;
    logic [6:0] rx_channel, tx_channel, last_ch;
    logic [7:0] air_tx_data, rd;
    logic [9:0] cfg;
    logic [7:0] sent[$];
    int mismatches = 0, comparisons = 0, starts = 0;

    always #2.5 ref_clk = ~ref_clk;

    rmhsp_core dut (
        .ref_clk, .srst, .sck, .select_n, .mosi, .miso, .miso_oe, .byte_ready,
        .command_unlock_req_n, .command_ack, .country_code, .rssi_value, .hop_set,
        .lead_in_sel, .baud_sel, .baud_alt, .rx_slow, .lead_freq_sel, .rx_scan, .rx_channel,
        .tx_start, .tx_next_hop, .tx_channel, .tx_lead_done, .tx_byte_done, .tx_frame_done,
        .air_tx_valid, .air_tx_ready, .air_tx_data, .rx_enable, .rx_lead_found, .rx_lead_lost,
        .rx_sync_found, .rx_byte_valid, .rx_byte, .rx_frame_end
    );
    rmhsp_host host (.sck, .select_n, .mosi, .miso, .miso_oe);

    // count transmit starts mid-cycle, away from the edge that launches the pulse
    always @(negedge ref_clk) begin
        if (tx_start === 1'b1) begin
            starts++;
            last_ch = tx_channel;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wait_on(ref logic s, input logic lvl);
        for (int n = 0; n < 400 && s !== lvl; n++) tick(1);
        chk(16'(s), 16'(lvl));
    endtask
    task automatic cmd(input logic [7:0] b);
        tick(1);
        host.xfer(b, rd);
        tick(8); // decode lands a few cycles after the last rise
    endtask
    task automatic rd_byte(input logic [7:0] exp);
        tick(1);
        host.xfer(CMD_NOP, rd);
        chk(16'(rd), 16'(exp));
    endtask
    function automatic logic [9:0] cfg_now();
        return {hop_set, lead_in_sel, baud_sel, rx_slow, lead_freq_sel};
    endfunction
    // expected config after one byte; unlisted codes leave it alone
    function automatic logic [9:0] cfg_next(logic [9:0] c, logic [7:0] b);
        if (b inside {[8'hf0:8'hf7]}) c[9:7] = b[2:0];
        if (b inside {[8'hf8:8'hfa]}) c[6:5] = b[1:0];
        if (b inside {8'h73, 8'h75, 8'h76}) c[4:3] = b[2:1] - 2'h1;
        if (b inside {8'h78, 8'h79}) c[2] = ~b[0];
        if (b inside {[8'h7a:8'h7d]}) c[1:0] = b[1:0] - 2'h2;
        return c;
    endfunction

    initial begin
        logic [7:0] b;
        void'($urandom(32'hf96aff53));
        repeat (20) @(posedge ref_clk);
        #1 srst = 1'b0;
        tick(4);
        cfg = {HOP_RESET, LEAD_30MS, BAUD_LOW, 1'b0, LIF_RESET};
        chk(16'(cfg_now()), 16'(cfg));
        chk(16'({byte_ready, command_ack, rx_scan}), 16'h1);
        note("reset");
        for (int i = 0; i < 64; i++) begin
            b = (i < 32) ? 8'(i) : 8'($urandom);
            b = {b[4] ? 4'hf : 4'h7, b[3:0]};
            if (b != CMD_COUNTRY) begin
                cmd(b);
                cfg = cfg_next(cfg, b);
                chk(16'(cfg_now()), 16'(cfg));
            end
        end
        note("config");
        for (int c = 0; c < 4; c++) begin
            country_code = 2'(c);
            cmd(CMD_COUNTRY);
            wait_on(byte_ready, 1'b1);
            rd_byte(8'(c));
            chk(16'(baud_alt), 16'(c == 3));
        end
        rssi_value = 8'($urandom);
        cmd(CMD_RSSI);
        wait_on(byte_ready, 1'b1);
        rd_byte(rssi_value);
        note("answers");
        b = 8'($urandom_range(100));
        cmd(CMD_RX_FIX);
        cmd(b);
        chk(16'({rx_scan, rx_channel}), 16'(b));
        chk(16'(rx_enable), 16'h1);
        b = {5'b11110, ~cfg[9:7]};
        cmd(b);
        chk(16'(hop_set), 16'(cfg[9:7]));
        command_unlock_req_n = 1'b0;
        wait_on(command_ack, 1'b1);
        command_unlock_req_n = 1'b1;
        chk(16'(rx_enable), 16'h0);
        cmd(b);
        chk(16'({command_ack, hop_set}), 16'({1'b1, b[2:0]}));
        cmd(CMD_RX_SCAN);
        chk(16'({command_ack, rx_scan}), 16'h1);
        note("unlock");
        pulse(rx_lead_found);
        wait_on(byte_ready, 1'b1);
        rd_byte(CODE_LEAD_FOUND);
        rssi_value = 8'($urandom);
        pulse(rx_sync_found);
        wait_on(byte_ready, 1'b1);
        rd_byte(rssi_value);
        for (int k = 0; k < 3; k++) begin
            rx_byte = 8'($urandom);
            pulse(rx_byte_valid);
            wait_on(byte_ready, 1'b1);
            rd_byte(rx_byte);
        end
        pulse(rx_frame_end);
        tick(4);
        pulse(rx_lead_found);
        wait_on(byte_ready, 1'b1);
        rd_byte(CODE_LEAD_FOUND);
        pulse(rx_lead_lost);
        wait_on(byte_ready, 1'b1);
        rd_byte(CODE_LEAD_LOST);
        note("receive");
        tick(4);
        b = 8'(CMD_TX_CH_FIRST + $urandom_range(100));
        cmd(b);
        chk(16'({tx_next_hop, 4'(starts), last_ch}),
            16'({1'b0, 4'h1, 7'(b - CMD_TX_CH_FIRST)}));
        pulse(tx_lead_done);
        // fill the fifo while the air side stalls
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            wait_on(byte_ready, 1'b1);
            sent.push_back(8'($urandom));
            host.xfer(sent[k], rd);
            chk(16'(byte_ready), 16'h0);
            tick(1);
            pulse(tx_byte_done);
        end
        tick(20);
        chk(16'({byte_ready, air_tx_valid}), 16'h1);
        air_tx_ready = 1'b1;
        for (int n = 0; n < 100 && sent.size() > 0; n++) begin
            if (air_tx_valid === 1'b1) chk(16'(air_tx_data), 16'(sent.pop_front()));
            tick(1);
        end
        chk(16'({air_tx_valid, 5'(sent.size())}), 16'h0);
        pulse(tx_byte_done);
        wait_on(byte_ready, 1'b1);
        tick(40);
        chk(16'(byte_ready), 16'h1);
        pulse(tx_frame_done);
        wait_on(byte_ready, 1'b0);
        cmd(CMD_TX_NEXT);
        chk(16'({tx_next_hop, 4'(starts)}), 16'h12);
        pulse(tx_lead_done);
        wait_on(byte_ready, 1'b1);
        pulse(tx_frame_done);
        note("transmit");
        close_out();
    end

    // hang guard, well past the longest expected run
    initial begin
        #200us;
        mismatches++;
        close_out();
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
endmodule
